// ### design/acmcr_core_mode_regs.sv
`timescale 1ns/1ps
// Functional notes
// - clock mode resets 0001, bit0 staggers cores
// - interleave bit zero aligns all core clocks
// - clock mode bit1 halves input clock rate
// - staggered sets: all four, A+B, C+D
// - two-core staggered: half period offset each
// - simultaneous: active cores sample and output together
// - standby bit0 powers down selected cores
// - pointer picks core or all; others persist
// - swing bit: zero reduced, one standard swing
// - impedance trim 4 bits, rw 1C, ro 70
// - source select defaults zero, bit3 stays zero
// - host impedance value only when bit2 set
// - zero source bits always mean factory values
// - bit1 common mode, bit0 offset source
module acmcr_core_mode_regs #(
   parameter int unsigned NUM_CORES = 4,
   parameter int unsigned IMP_W = acmcr_pkg::IMP_W
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   input wire logic [IMP_W-1:0] factory_imp_trim,
   output logic core_interleave,
   output logic input_clock_halve,
   output logic sample_enable,
   output logic [NUM_CORES-1:0] core_power_down,
   output logic [2*NUM_CORES-1:0] core_phase,
   output logic stagger_set_legal,
   output logic output_swing_full,
   output logic [IMP_W-1:0] imp_trim_eff,
   output logic imp_source_bit,
   output logic common_mode_source_bit,
   output logic offset_source_bit
);
   // the pointer codes, phase table and per-core standby assume four cores
   if (NUM_CORES != 4) begin : g_bad_cores
      $error("this block serves exactly four cores");
   end
   if (IMP_W != acmcr_pkg::IMP_W) begin : g_bad_imp
      $error("impedance trim width is fixed by the register layout");
   end

   localparam int unsigned AW = acmcr_pkg::ADDR_W;
   localparam int unsigned DW = acmcr_pkg::DATA_W;

   // bus strobes from the serial slave
   logic reg_wr; // one-cycle write strobe
   logic reg_rd; // one-cycle read strobe
   logic [AW-1:0] reg_addr; // decoded address
   logic [DW-1:0] reg_wdata; // written word
   logic [DW-1:0] reg_rdata; // read mux result

   // stored registers
   logic [2:0] chan_ptr_q; // core pointer for per-core registers
   logic [1:0] clk_mode_q; // interleave and halve bits
   logic [2:0] src_sel_q; // trim source choices, bit3 not stored
   logic [IMP_W-1:0] imp_trim_q; // host impedance trim
   logic [NUM_CORES-1:0] pwr_down_q; // per-core standby
   logic swing_q; // output swing choice
   logic halve_ph_q; // divide-by-two phase
   logic [IMP_W-1:0] imp_eff; // impedance in effect
   logic [NUM_CORES-1:0] ptr_cores; // cores hit by the pointer
   logic [1:0] n_active; // active core count, low bits
   logic all_active; // every core powered
   logic pair_ab; // only cores A and B powered
   logic pair_cd; // only cores C and D powered
   logic [2*NUM_CORES-1:0] phase_d; // next core phase word

   // serial front end
   acmcr_spi_slave #(
      .ADDR_W(AW),
      .DATA_W(DW)
   ) u_spi (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe_n(spi_miso_oe_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // host trim reset value taken from the upper nibble of the default word
   localparam logic [IMP_W-1:0] IMP_RESET =
      acmcr_pkg::IMP_TRIM_RESET_WORD[DW-1 -: IMP_W];

   // channel pointer, three bits kept so the master code 7 fits
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         chan_ptr_q <= acmcr_pkg::CHAN_PTR_RESET[2:0];
      end else if (reg_wr && reg_addr == acmcr_pkg::CHAN_PTR_ADDR) begin
         chan_ptr_q <= reg_wdata[2:0];
      end
   end

   // clock mode: staggered timing out of reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         clk_mode_q <= acmcr_pkg::CLK_MODE_RESET[1:0];
      end else if (reg_wr && reg_addr == acmcr_pkg::CLK_MODE_ADDR) begin
         // upper bits are dropped so they read back as zero
         clk_mode_q <= reg_wdata[1:0];
      end
   end

   // source select: only bits 2..0 exist, bit 3 is wired to zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         src_sel_q <= acmcr_pkg::SRC_SEL_RESET[2:0];
      end else if (reg_wr && reg_addr == acmcr_pkg::SRC_SEL_ADDR) begin
         // the new word replaces all choices at once, so a zero bit
         // falls back to factory whatever was chosen before
         src_sel_q <= reg_wdata[2:0];
      end
   end

   // host impedance trim, stored even while factory value rules
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         imp_trim_q <= IMP_RESET;
      end else if (reg_wr && reg_addr == acmcr_pkg::IMP_TRIM_ADDR) begin
         imp_trim_q <= reg_wdata[IMP_W-1:0];
      end
   end

   // output swing choice, reduced out of reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         swing_q <= acmcr_pkg::SWING_RESET[acmcr_pkg::SWING_BIT];
      end else if (reg_wr && reg_addr == acmcr_pkg::SWING_ADDR) begin
         swing_q <= reg_wdata[acmcr_pkg::SWING_BIT];
      end
   end

   // cores addressed by the pointer; master code reaches no core
   always_comb begin
      ptr_cores = '0;
      if (chan_ptr_q == acmcr_pkg::CHAN_ALL) begin
         ptr_cores = '1;
      end else if (chan_ptr_q < acmcr_pkg::CHAN_ALL) begin
         ptr_cores[chan_ptr_q[1:0]] = 1'b1;
      end
   end

   // standby: only addressed cores change, the rest keep their state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pwr_down_q <= {NUM_CORES{acmcr_pkg::PWR_DOWN_RESET}};
      end else if (reg_wr && reg_addr == acmcr_pkg::PWR_DOWN_ADDR) begin
         for (int i = 0; i < NUM_CORES; i++) begin
            if (ptr_cores[i]) begin
               pwr_down_q[i] <= reg_wdata[acmcr_pkg::PWR_DOWN_BIT];
            end
         end
      end
   end

   // impedance in effect: host value only while its source bit is set
   always_comb begin
      if (src_sel_q[acmcr_pkg::SRC_IMP_BIT]) begin
         imp_eff = imp_trim_q;
      end else begin
         imp_eff = factory_imp_trim;
      end
   end

   // which staggered core set is powered
   always_comb begin
      all_active = pwr_down_q == 4'h0;
      pair_ab = pwr_down_q == 4'hc;
      pair_cd = pwr_down_q == 4'h3;
      n_active = 2'(!pwr_down_q[0]) + 2'(!pwr_down_q[1])
         + 2'(!pwr_down_q[2]) + 2'(!pwr_down_q[3]);
   end

   // core sampling phase, in quarters of the external clock period;
   // powered-down cores sit at phase zero only in the pair sets and aligned mode
   always_comb begin
      phase_d = '0;
      if (clk_mode_q[acmcr_pkg::CLK_INTERLEAVE_BIT]) begin
         if (pair_ab) begin
            // two cores take half a period each
            phase_d[3:2] = acmcr_pkg::PHASE_HALF;
         end else if (pair_cd) begin
            phase_d[7:6] = acmcr_pkg::PHASE_HALF;
         end else begin
            // quarter step per core
            for (int i = 0; i < NUM_CORES; i++) begin
               phase_d[2*i +: 2] = 2'(i);
            end
         end
      end else begin
         // aligned: every active core samples and outputs together
         phase_d = '0;
      end
   end

   // divide-by-two runs as an every-other-cycle sampling enable
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         halve_ph_q <= 1'b0;
         sample_enable <= 1'b1;
      end else if (clk_mode_q[acmcr_pkg::CLK_HALVE_BIT]) begin
         halve_ph_q <= ~halve_ph_q;
         sample_enable <= halve_ph_q;
      end else begin
         halve_ph_q <= 1'b0;
         sample_enable <= 1'b1;
      end
   end

   // registered copies of the settings for the converter
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_interleave <= acmcr_pkg::CLK_MODE_RESET[acmcr_pkg::CLK_INTERLEAVE_BIT];
         input_clock_halve <= acmcr_pkg::CLK_MODE_RESET[acmcr_pkg::CLK_HALVE_BIT];
         core_power_down <= {NUM_CORES{acmcr_pkg::PWR_DOWN_RESET}};
         core_phase <= '0;
         output_swing_full <= acmcr_pkg::SWING_RESET[acmcr_pkg::SWING_BIT];
      end else begin
         core_interleave <= clk_mode_q[acmcr_pkg::CLK_INTERLEAVE_BIT];
         input_clock_halve <= clk_mode_q[acmcr_pkg::CLK_HALVE_BIT];
         core_power_down <= pwr_down_q;
         core_phase <= phase_d;
         output_swing_full <= swing_q;
      end
   end

   // trim sources and the value in effect
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         imp_trim_eff <= '0;
         imp_source_bit <= acmcr_pkg::SRC_SEL_RESET[acmcr_pkg::SRC_IMP_BIT];
         common_mode_source_bit <= acmcr_pkg::SRC_SEL_RESET[acmcr_pkg::SRC_CM_BIT];
         offset_source_bit <= acmcr_pkg::SRC_SEL_RESET[acmcr_pkg::SRC_OFFSET_BIT];
      end else begin
         imp_trim_eff <= imp_eff;
         imp_source_bit <= src_sel_q[acmcr_pkg::SRC_IMP_BIT];
         common_mode_source_bit <= src_sel_q[acmcr_pkg::SRC_CM_BIT];
         offset_source_bit <= src_sel_q[acmcr_pkg::SRC_OFFSET_BIT];
      end
   end

   // flags a staggered setting the host must not use: it is legal only
   // with all four cores or one of the two pairs powered
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stagger_set_legal <= 1'b1;
      end else begin
         stagger_set_legal <= !clk_mode_q[acmcr_pkg::CLK_INTERLEAVE_BIT]
            || all_active || pair_ab || pair_cd;
      end
   end

   // read mux; reserved bits and unmapped addresses read as zero
   always_comb begin
      reg_rdata = '0;
      unique case (reg_addr)
         acmcr_pkg::CHAN_PTR_ADDR: begin
            reg_rdata[2:0] = chan_ptr_q;
         end
         acmcr_pkg::CLK_MODE_ADDR: begin
            reg_rdata[1:0] = clk_mode_q;
         end
         acmcr_pkg::SRC_SEL_ADDR: begin
            // bit 3 and above stay zero
            reg_rdata[2:0] = src_sel_q;
         end
         acmcr_pkg::IMP_TRIM_ADDR: begin
            reg_rdata[IMP_W-1:0] = imp_trim_q;
         end
         acmcr_pkg::IMP_READ_ADDR: begin
            // read-only view of the value actually applied
            reg_rdata[IMP_W-1:0] = imp_eff;
         end
         acmcr_pkg::PWR_DOWN_ADDR: begin
            // all-cores pointer reads set only when every core sleeps
            reg_rdata[acmcr_pkg::PWR_DOWN_BIT] =
               (ptr_cores != '0) && ((pwr_down_q & ptr_cores) == ptr_cores);
         end
         acmcr_pkg::SWING_ADDR: begin
            reg_rdata[acmcr_pkg::SWING_BIT] = swing_q;
         end
         default: begin
            reg_rdata = '0;
         end
      endcase
   end

   // n_active and reg_rd are unused and only tied off here
   logic unused_ok;
   assign unused_ok = &{1'b0, n_active, reg_rd};
endmodule

// ### pkg/acmcr_pkg.sv
package acmcr_pkg;
   // serial frame layout: one direction bit, address, data word
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned HEAD_W = 8;
   localparam logic DIR_WRITE = 1'b1;

   // register addresses
   localparam logic [6:0] CHAN_PTR_ADDR = 7'h01;
   localparam logic [6:0] CLK_MODE_ADDR = 7'h07;
   localparam logic [6:0] SRC_SEL_ADDR = 7'h16;
   localparam logic [6:0] IMP_TRIM_ADDR = 7'h1c;
   localparam logic [6:0] PWR_DOWN_ADDR = 7'h5c;
   localparam logic [6:0] SWING_ADDR = 7'h6a;
   localparam logic [6:0] IMP_READ_ADDR = 7'h70;

   // field positions
   localparam int unsigned CLK_INTERLEAVE_BIT = 0;
   localparam int unsigned CLK_HALVE_BIT = 1;
   localparam int unsigned SRC_OFFSET_BIT = 0;
   localparam int unsigned SRC_CM_BIT = 1;
   localparam int unsigned SRC_IMP_BIT = 2;
   localparam int unsigned PWR_DOWN_BIT = 0;
   localparam int unsigned SWING_BIT = 0;
   localparam int unsigned IMP_W = 4;
   localparam int unsigned PTR_W = 3;

   // reset values
   localparam logic [15:0] CLK_MODE_RESET = 16'h0001;
   localparam logic [15:0] SRC_SEL_RESET = 16'h0000;
   localparam logic [15:0] IMP_TRIM_RESET_WORD = 16'h8000;
   localparam logic [15:0] SWING_RESET = 16'h0000;
   localparam logic [15:0] CHAN_PTR_RESET = 16'h0004;
   localparam logic PWR_DOWN_RESET = 1'b0;

   // writable bits of each register; all others read zero
   localparam logic [15:0] CLK_MODE_MASK = 16'h0003;
   localparam logic [15:0] SRC_SEL_MASK = 16'h0007;
   localparam logic [15:0] IMP_MASK = 16'h000f;
   localparam logic [15:0] PWR_MASK = 16'h0001;
   localparam logic [15:0] SWING_MASK = 16'h0001;
   localparam logic [15:0] PTR_MASK = 16'h0007;

   // channel pointer codes
   localparam logic [2:0] CHAN_ALL = 3'h4;
   localparam logic [2:0] CHAN_MASTER = 3'h7;

   // core clock phase in quarters of the external period
   localparam logic [1:0] PHASE_ZERO = 2'h0;
   localparam logic [1:0] PHASE_HALF = 2'h2;
endpackage

// ### design/acmcr_spi_slave.sv
`timescale 1ns/1ps
module acmcr_spi_slave #(
   parameter int unsigned ADDR_W = acmcr_pkg::ADDR_W,
   parameter int unsigned DATA_W = acmcr_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata
);
   localparam int unsigned FRAME_W = acmcr_pkg::HEAD_W + DATA_W;

   // the head holds direction plus address, and the 5-bit counter spans the frame
   if (ADDR_W + 1 != acmcr_pkg::HEAD_W || DATA_W < ADDR_W || FRAME_W > 31) begin : g_bad_head
      $error("frame layout does not fit the head or the bit counter");
   end

   typedef enum logic [1:0] {ACMCR_IDLE, ACMCR_HEAD, ACMCR_BODY} acmcr_frame_t;

   acmcr_frame_t phase_q; // where in the frame we are
   logic sclk_q; // last sampled serial clock
   logic [4:0] cnt_q; // bits taken this frame
   logic [DATA_W-1:0] shin_q; // incoming bits
   logic [DATA_W-1:0] shout_q; // read word being sent
   logic write_q; // direction of this frame
   logic rise;
   logic fall;

   // pins are synchronous to sys_clk, so plain edge detection suffices
   assign rise = spi_sclk & ~sclk_q;
   assign fall = ~spi_sclk & sclk_q;

   // serial clock history
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_sclk;
      end
   end

   // frame capture: head gives direction and address, body the word
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         phase_q <= ACMCR_IDLE;
         cnt_q <= 5'h00;
         shin_q <= '0;
         write_q <= 1'b0;
         reg_addr <= '0;
         reg_wdata <= '0;
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end else begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         if (spi_cs_n) begin
            // a frame cut short is dropped whole
            phase_q <= ACMCR_IDLE;
            cnt_q <= 5'h00;
         end else if (rise) begin
            shin_q <= {shin_q[DATA_W-2:0], spi_mosi};
            cnt_q <= cnt_q + 5'h01;
            unique case (phase_q)
               ACMCR_IDLE, ACMCR_HEAD: begin
                  phase_q <= ACMCR_HEAD;
                  if (cnt_q == 5'(acmcr_pkg::HEAD_W - 1)) begin
                     phase_q <= ACMCR_BODY;
                     write_q <= shin_q[ADDR_W-1] == acmcr_pkg::DIR_WRITE;
                     reg_addr <= {shin_q[ADDR_W-2:0], spi_mosi};
                     reg_rd <= shin_q[ADDR_W-1] != acmcr_pkg::DIR_WRITE;
                  end
               end
               ACMCR_BODY: begin
                  if (cnt_q == 5'(FRAME_W - 1)) begin
                     phase_q <= ACMCR_IDLE;
                     reg_wdata <= {shin_q[DATA_W-2:0], spi_mosi};
                     reg_wr <= write_q;
                  end
               end
            endcase
         end
      end
   end

   // read word leaves msb first, changing on falling edges
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         shout_q <= '0;
         spi_miso <= 1'b0;
      end else if (reg_rd) begin
         shout_q <= reg_rdata;
      end else if (fall && !spi_cs_n && phase_q == ACMCR_BODY && !write_q) begin
         spi_miso <= shout_q[DATA_W-1];
         shout_q <= {shout_q[DATA_W-2:0], 1'b0};
      end
   end

   // drive the data-out pin only during the body of a read
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         spi_miso_oe_n <= 1'b1;
      end else begin
         spi_miso_oe_n <= spi_cs_n | write_q | (phase_q != ACMCR_BODY);
      end
   end
endmodule

// ### tb/acmcr_regs_monitor.sv
`timescale 1ns/1ps
// watches the configuration outputs of the core mode register block
module acmcr_regs_monitor #(
   parameter int unsigned NUM_CORES = 4,
   parameter int unsigned IMP_W = 4
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe_n,
   input wire logic [IMP_W-1:0] factory_imp_trim,
   input wire logic core_interleave,
   input wire logic input_clock_halve,
   input wire logic sample_enable,
   input wire logic [NUM_CORES-1:0] core_power_down,
   input wire logic [2*NUM_CORES-1:0] core_phase,
   input wire logic stagger_set_legal,
   input wire logic output_swing_full,
   input wire logic [IMP_W-1:0] imp_trim_eff,
   input wire logic imp_source_bit
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // phase flops lag their cause by one edge, so only settled modes are judged
   sequence s_settled;
      $past(resetn) && $stable(core_interleave) && $stable(core_power_down);
   endsequence
   property p_aligned;
      s_settled ##0 !core_interleave |-> core_phase == '0;
   endproperty
   a_aligned: assert property (p_aligned) else $error("core clocks not aligned");
   property p_quarter;
      s_settled ##0 (core_interleave && core_power_down == 4'h0) |-> core_phase == 8'he4;
   endproperty
   a_quarter: assert property (p_quarter) else $error("quarter stagger wrong");
   property p_pair_ab;
      s_settled ##0 (core_interleave && core_power_down == 4'hc) |-> core_phase[3:0] == 4'h8;
   endproperty
   a_pair_ab: assert property (p_pair_ab) else $error("pair a b phase wrong");
   property p_pair_cd;
      s_settled ##0 (core_interleave && core_power_down == 4'h3) |-> core_phase[7:6] == 2'h2;
   endproperty
   a_pair_cd: assert property (p_pair_cd) else $error("pair c d phase wrong");
   property p_legal;
      s_settled |-> stagger_set_legal ==
         (!core_interleave || core_power_down inside {4'h0, 4'hc, 4'h3});
   endproperty
   a_legal: assert property (p_legal) else $error("stagger set flag wrong");
   property p_halve_toggle;
      input_clock_halve [*3] |-> sample_enable != $past(sample_enable);
   endproperty
   a_halve_toggle: assert property (p_halve_toggle) else $error("halving not toggling");
   property p_no_halve;
      (!input_clock_halve) [*3] |-> sample_enable;
   endproperty
   a_no_halve: assert property (p_no_halve) else $error("sample enable dropped");
   // the applied trim follows the factory input unless the host source is chosen
   property p_imp_factory;
      $past(resetn) && !imp_source_bit && $stable(imp_source_bit) && $stable(factory_imp_trim)
         |-> imp_trim_eff == factory_imp_trim;
   endproperty
   a_imp_factory: assert property (p_imp_factory) else $error("factory trim not used");
   property p_quiet;
      $past(resetn) && spi_cs_n && $past(spi_cs_n) && $past(spi_cs_n, 2) |->
         $stable(core_power_down) && $stable(output_swing_full) && $stable(core_interleave);
   endproperty
   a_quiet: assert property (p_quiet) else $error("settings moved while idle");
   property p_oe;
      spi_cs_n |=> spi_miso_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("read data driven while idle");
endmodule

// ### tb/acmcr_host_model.sv
`timescale 1ns/1ps
// behavioural host: frames of direction bit, seven address bits, sixteen data bits
module acmcr_host_model (
   input wire logic sys_clk,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe_n
);
   localparam int HOLD = 4; // two above the two-clock minimum, for margin
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   // let n edges pass, then step off the edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // one frame; nb below 24 drops select early and aborts it
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d,
                       input int nb, output logic [15:0] q);
      logic [23:0] fr;
      fr = {wr, a, d};
      q = 16'h0000;
      spi_cs_n = 1'b0;
      step(HOLD);
      for (int i = 0; i < nb; i++) begin
         spi_sclk = 1'b0;
         spi_mosi = fr[23-i];
         step(HOLD);
         // read body: the wire only carries data while the device enables it
         if (!wr && i >= 8) begin
            q[23-i] = spi_miso_oe_n ? 1'bx : spi_miso;
         end
         spi_sclk = 1'b1;
         step(HOLD);
      end
      spi_sclk = 1'b0;
      step(HOLD);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // released line never shows a stale bit
      step(HOLD);
   endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic sys_clk;
   logic resetn;
   logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n;
   logic [3:0] factory_imp_trim, core_power_down, imp_trim_eff;
   logic core_interleave, input_clock_halve, sample_enable, stagger_set_legal;
   logic output_swing_full, imp_source_bit, common_mode_source_bit, offset_source_bit;
   logic [7:0] core_phase;
   int num_errors = 0; // mismatches
   int comparisons = 0; // checks made
   int cycles = 0; // watchdog count
   // bench model of the register file
   logic [15:0] m_clk = 16'h0001, m_src = 16'h0000, m_imp = 16'h0008, m_swg = 16'h0000;
   logic [15:0] m_ptr = 16'h0004, q;
   logic [3:0] m_pd = 4'h0;
   // 33 is unmapped
   logic [6:0] addrs [8] = '{7'h01, 7'h07, 7'h16, 7'h1c, 7'h5c, 7'h6a, 7'h70, 7'h33};
   // standby steps: pointer in the high nibble, standby bit in the low
   int sp [10] = '{8'h01, 8'h11, 8'h00, 8'h10, 8'h21, 8'h31, 8'h11, 8'h41, 8'h71, 8'h40};
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   acmcr_host_model host (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));
   acmcr_core_mode_regs #(.NUM_CORES(4), .IMP_W(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe_n(spi_miso_oe_n), .factory_imp_trim(factory_imp_trim),
      .core_interleave(core_interleave), .input_clock_halve(input_clock_halve),
      .sample_enable(sample_enable), .core_power_down(core_power_down),
      .core_phase(core_phase), .stagger_set_legal(stagger_set_legal),
      .output_swing_full(output_swing_full), .imp_trim_eff(imp_trim_eff),
      .imp_source_bit(imp_source_bit), .common_mode_source_bit(common_mode_source_bit),
      .offset_source_bit(offset_source_bit));
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h, seen %h", n, exp, seen);
      end
   endtask
   function automatic logic [3:0] m_eff();
      return m_src[2] ? m_imp[3:0] : factory_imp_trim;
   endfunction
   function automatic logic [15:0] m_read(input logic [6:0] a);
      case (a)
         7'h01: return m_ptr;
         7'h07: return m_clk;
         7'h16: return m_src;
         7'h1c: return m_imp;
         7'h5c: return (m_ptr < 4) ? 16'(m_pd[m_ptr[1:0]]) : 16'(m_ptr == 4 && &m_pd);
         7'h6a: return m_swg;
         7'h70: return {12'h000, m_eff()};
         default: return 16'h0000;
      endcase
   endfunction
   // write through the host and mirror it in the model
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host.xfer(1'b1, a, d, 24, q);
      case (a)
         7'h01: m_ptr = d & 16'h0007;
         7'h07: m_clk = d & 16'h0003;
         7'h16: m_src = d & 16'h0007;
         7'h1c: m_imp = d & 16'h000f;
         7'h5c: begin
            if (m_ptr < 4) m_pd[m_ptr[1:0]] = d[0];
            else if (m_ptr == 4) m_pd = {4{d[0]}};
         end
         7'h6a: m_swg = d & 16'h0001;
         default: ;
      endcase
   endtask
   task automatic rd_chk(input logic [6:0] a);
      logic [15:0] r;
      host.xfer(1'b0, a, 16'($urandom), 24, r);
      check($sformatf("register %h", a), r, m_read(a));
   endtask
   task automatic chk_outs();
      logic legal;
      legal = !m_clk[0] || m_pd == 4'h0 || m_pd == 4'hc || m_pd == 4'h3;
      check("interleave", 16'(core_interleave), 16'(m_clk[0]));
      check("halve", 16'(input_clock_halve), 16'(m_clk[1]));
      check("power down", 16'(core_power_down), 16'(m_pd));
      check("swing", 16'(output_swing_full), 16'(m_swg[0]));
      check("trim", 16'(imp_trim_eff), 16'(m_eff()));
      check("sources",
         16'({imp_source_bit, common_mode_source_bit, offset_source_bit}), 16'(m_src[2:0]));
      check("stagger legal", 16'(stagger_set_legal), 16'(legal));
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog: about 100 frames of some 210 cycles each are expected
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      resetn = 1'b0;
      factory_imp_trim = 4'h5;
      void'($urandom(92679));
      repeat (12) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      foreach (addrs[i]) rd_chk(addrs[i]);
      chk_outs();
      $display("test reset done");
      // random words everywhere except standby; ignored bits must vanish
      for (int k = 0; k < 3; k++) begin
         foreach (addrs[i]) begin
            if (addrs[i] != 7'h5c) begin
               wr(addrs[i], 16'($urandom));
               rd_chk(addrs[i]);
               chk_outs();
            end
         end
         factory_imp_trim = 4'($urandom);
      end
      $display("test registers done");
      for (int v = 0; v < 4; v++) begin
         wr(7'h07, 16'(v));
         chk_outs();
      end
      $display("test clock mode done");
      wr(7'h07, 16'h0001);
      foreach (sp[i]) begin
         wr(7'h01, 16'(sp[i] >> 4));
         wr(7'h5c, 16'(sp[i] & 1));
         chk_outs();
         rd_chk(7'h5c);
      end
      wr(7'h07, 16'h0000);
      wr(7'h01, 16'h0002);
      wr(7'h5c, 16'h0001);
      chk_outs();
      $display("test standby done");
      wr(7'h01, 16'h0007);
      host.xfer(1'b0, 7'h16, 16'h0000, 24, q);
      check("source before update", q, m_src);
      wr(7'h16, q | 16'h0004);
      wr(7'h1c, 16'($urandom));
      factory_imp_trim = ~factory_imp_trim;
      rd_chk(7'h70);
      chk_outs();
      wr(7'h16, 16'h0000);
      rd_chk(7'h70);
      chk_outs();
      $display("test impedance done");
      // frame cut short must leave the clock mode untouched
      host.xfer(1'b1, 7'h07, ~m_clk, 9 + $urandom_range(14), q);
      rd_chk(7'h07);
      chk_outs();
      $display("test abort done");
      test_done();
   end
endmodule
bind acmcr_core_mode_regs acmcr_regs_monitor #(.NUM_CORES(NUM_CORES), .IMP_W(IMP_W)) u_mon (
   .sys_clk(sys_clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
   .factory_imp_trim(factory_imp_trim), .core_interleave(core_interleave),
   .input_clock_halve(input_clock_halve), .sample_enable(sample_enable),
   .core_power_down(core_power_down), .core_phase(core_phase),
   .stagger_set_legal(stagger_set_legal), .output_swing_full(output_swing_full),
   .imp_trim_eff(imp_trim_eff), .imp_source_bit(imp_source_bit));
